// ==== sig_pkg.sv ====
// Register map, field positions and constants for the gain and exposure control bank
package sig_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int SIG_NREG = 33;
  localparam int SIG_IW   = 6;

  localparam logic [15:0] SIG_ADDR [SIG_NREG] = '{
    16'h3500, 16'h3501, 16'h3502, 16'h3503, 16'h3504, 16'h3505, 16'h3506, 16'h3507,
    16'h3508, 16'h3509, 16'h350a, 16'h350b, 16'h350e, 16'h350f, 16'h3514, 16'h3515,
    16'h5000, 16'h5001, 16'h5056, 16'h5057, 16'h5058, 16'h5059, 16'h505a, 16'h505b,
    16'h5238, 16'h5239, 16'h523a, 16'h523b, 16'h523c, 16'h523d, 16'h523e, 16'h523f,
    16'h5240};

  localparam logic [7:0] SIG_RESET [SIG_NREG] = '{
    8'h00, 8'h02, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02,
    8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h00,
    8'h08, 8'h01, 8'h04, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00,
    8'haa, 8'haa, 8'haa, 8'haa, 8'haa, 8'h88, 8'h40, 8'h20,
    8'h18};

  // Implemented bits; the rest read as zero
  localparam logic [7:0] SIG_MASK [SIG_NREG] = '{
    8'h0f, 8'hff, 8'hff, 8'h37, 8'h03, 8'hff, 8'h0f, 8'hff,
    8'hff, 8'h1b, 8'h07, 8'hff, 8'h07, 8'hff, 8'h03, 8'hff,
    8'hff, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h7f};

  // Register indices
  localparam int SIG_I_LEXP_H   = 0;
  localparam int SIG_I_LEXP_M   = 1;
  localparam int SIG_I_LEXP_L   = 2;
  localparam int SIG_I_MANUAL   = 3;
  localparam int SIG_I_MLGAIN_H = 4;
  localparam int SIG_I_MLGAIN_L = 5;
  localparam int SIG_I_SEXP_H   = 6;
  localparam int SIG_I_SEXP_M   = 7;
  localparam int SIG_I_SEXP_L   = 8;
  localparam int SIG_I_GCONV    = 9;
  localparam int SIG_I_LGOUT_H  = 10;
  localparam int SIG_I_LGOUT_L  = 11;
  localparam int SIG_I_SGOUT_H  = 12;
  localparam int SIG_I_SGOUT_L  = 13;
  localparam int SIG_I_MSGAIN_H = 14;
  localparam int SIG_I_MSGAIN_L = 15;
  localparam int SIG_I_CTRL0    = 16;
  localparam int SIG_I_CTRL1    = 17;
  localparam int SIG_I_WB_R_H   = 18;
  localparam int SIG_I_WB_G_H   = 20;
  localparam int SIG_I_WB_B_H   = 22;
  localparam int SIG_I_POINT0   = 24;
  localparam int SIG_NPOINT     = 5;
  localparam int SIG_I_BASE     = 29;
  localparam int SIG_I_UPPER    = 30;
  localparam int SIG_I_LOWER    = 31;
  localparam int SIG_I_MINAMP   = 32;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SIG_B_SHADE_EN     = 0;
  localparam int SIG_B_WHITE_DEF    = 1;
  localparam int SIG_B_BLACK_DEF    = 2;
  localparam int SIG_B_WB_EN        = 1;
  localparam int SIG_B_GAIN_DLY_SEL = 5;
  localparam int SIG_B_GAIN_DLY_EN  = 4;
  localparam int SIG_B_LONG_REAL    = 4;
  localparam int SIG_B_LONG_MAN     = 3;
  localparam int SIG_B_SHORT_REAL   = 1;
  localparam int SIG_B_SHORT_MAN    = 0;

  // ************************************************************
  // Gain, exposure and amplitude constants
  // ************************************************************
  localparam logic [11:0] SIG_WB_UNITY   = 12'h400;
  localparam logic [8:0]  SIG_GAIN_MAX16 = 9'h100;
  localparam logic [4:0]  SIG_CODED_BASE = 5'h10;
  localparam logic [6:0]  SIG_AMP_FULL   = 7'h40;
  localparam int          SIG_EXP_FRAC   = 4;

endpackage

// ==== sig_gain_exposure_ctrl.sv ====
// Gain, exposure, white balance, defect and lens shading control bank
//
// Operation
// - Each shading colour byte holds blue point high nibble, red point low nibble.
// - Base byte adds its high nibble to every blue point, its low nibble to every red point.
// - Auto switch on and gain above upper threshold gives minimum amplitude.
// - Amplitude decreases above lower threshold, unchanged below it.
// - Minimum amplitude is seven bits, software keeps it within zero to 64.
// - Pipeline byte 0 bits 2 and 1 enable black and white defect removal.
// - White balance gain per channel is twelve bits, 0x400 being unity.
// - White balance gains apply only while pipeline byte 1 bit 1 is set.
// - Long exposure is twenty bits over three bytes in sixteenths of line.
// - Short exposure uses the same layout for alternate row dynamic range.
// - Manual byte bit 5 picks delayed latch, bit 4 enables that delay.
// - Analog gain reaching the array never exceeds sixteen times.
// - Conversion bit 4 reads long gain as coded or real gain.
// - Conversion bit 3 selects manual long gain, which never triggers calibration.
// - Conversion bits 1 and 0 do the same for short gain.
// - Coded gain equals two to N times sixteen plus X over sixteen.
// - Real gain value carries four fractional bits.
// - Gain output values are eleven bits over two bytes, long gain unity at reset (short reads as coded 2x).
// - Manual sensor gain is ten bits over two bytes.
// - Pipeline byte 0 bit 0 enables lens shading compensation.
`timescale 1ns/1ps
`default_nettype none

module sig_gain_exposure_ctrl (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        frame_start,
  input  wire logic        auto_shading_switch_enable,
  output logic      [15:0] long_exposure_lines,
  output logic      [15:0] short_exposure_lines,
  output logic      [8:0]  long_analog_gain,
  output logic      [8:0]  short_analog_gain,
  output logic             long_gain_blc_allowed,
  output logic             short_gain_blc_allowed,
  output logic      [11:0] wb_red_gain,
  output logic      [11:0] wb_green_gain,
  output logic      [11:0] wb_blue_gain,
  output logic             black_defect_removal_en,
  output logic             white_defect_removal_en,
  output logic             lens_shading_correction_en,
  output logic      [24:0] shading_blue_points,
  output logic      [24:0] shading_red_points,
  output logic      [6:0]  shading_lum_amplitude
);

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [sig_pkg::SIG_IW:0] reg_lookup(input logic [15:0] addr);
    logic [sig_pkg::SIG_IW:0] res;
    res = '0;
    for (int i = 0; i < sig_pkg::SIG_NREG; i++) begin
      if (sig_pkg::SIG_ADDR[i] == addr) begin
        res = {1'b1, i[sig_pkg::SIG_IW-1:0]};
      end
    end
    return res;
  endfunction

  // Gain in sixteenths, clamped so the array never sees more than 16x
  function automatic logic [8:0] gain_x16(input logic [10:0] g, input logic real_mode);
    logic [2:0]  n;
    logic [11:0] coded;
    logic [10:0] v;
    n = 3'($countones(g[9:4]));
    coded = 12'({sig_pkg::SIG_CODED_BASE + {1'b0, g[3:0]}}) << n;
    v = real_mode ? g : coded[10:0];
    if (coded[11] || v > 11'(sig_pkg::SIG_GAIN_MAX16)) begin
      v = 11'(sig_pkg::SIG_GAIN_MAX16);
    end
    return v[8:0];
  endfunction

  // Point plus common base, one nibble field of each byte
  function automatic logic [4:0] point_sum(input logic [3:0] p, input logic [3:0] b);
    return {1'b0, p} + {1'b0, b};
  endfunction

  function automatic logic [11:0] wb_gain(input logic [7:0] hi, input logic [7:0] lo,
                                          input logic en);
    return en ? {hi[3:0], lo} : sig_pkg::SIG_WB_UNITY;
  endfunction

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0]               regs_r [sig_pkg::SIG_NREG];
  logic [sig_pkg::SIG_IW:0] hit;
  logic                     hit_valid;
  logic [sig_pkg::SIG_IW-1:0] hit_idx;

  assign hit       = reg_lookup(reg_addr);
  assign hit_valid = hit[sig_pkg::SIG_IW];
  assign hit_idx   = hit[sig_pkg::SIG_IW-1:0];

  // Unmapped writes are dropped; masked bits always read zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < sig_pkg::SIG_NREG; i++) begin
        regs_r[i] <= sig_pkg::SIG_RESET[i];
      end
    end else if (reg_write && hit_valid) begin
      regs_r[hit_idx] <= reg_wdata & sig_pkg::SIG_MASK[hit_idx];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      reg_rdata  <= (reg_read && hit_valid) ? regs_r[hit_idx] : 8'h00;
    end
  end

  // ************************************************************
  // Decoded controls
  // ************************************************************
  logic [7:0]  manual_mode;
  logic [7:0]  gconv;
  logic [7:0]  ctrl0;
  logic [7:0]  ctrl1;
  logic        gain_delay;
  logic [19:0] long_exp_raw;
  logic [19:0] short_exp_raw;
  logic [10:0] long_gain_src;
  logic [10:0] short_gain_src;
  logic [8:0]  long_gain_now;
  logic [8:0]  short_gain_now;

  assign manual_mode = regs_r[sig_pkg::SIG_I_MANUAL];
  assign gconv       = regs_r[sig_pkg::SIG_I_GCONV];
  assign ctrl0       = regs_r[sig_pkg::SIG_I_CTRL0];
  assign ctrl1       = regs_r[sig_pkg::SIG_I_CTRL1];

  // Delayed latch only when both the option and its enable are set
  assign gain_delay = manual_mode[sig_pkg::SIG_B_GAIN_DLY_SEL]
                    & manual_mode[sig_pkg::SIG_B_GAIN_DLY_EN];

  assign long_exp_raw  = {regs_r[sig_pkg::SIG_I_LEXP_H][3:0],
                          regs_r[sig_pkg::SIG_I_LEXP_M],
                          regs_r[sig_pkg::SIG_I_LEXP_L]};
  assign short_exp_raw = {regs_r[sig_pkg::SIG_I_SEXP_H][3:0],
                          regs_r[sig_pkg::SIG_I_SEXP_M],
                          regs_r[sig_pkg::SIG_I_SEXP_L]};

  // Manual source is ten bits; output value is eleven bits
  assign long_gain_src = gconv[sig_pkg::SIG_B_LONG_MAN]
    ? {1'b0, regs_r[sig_pkg::SIG_I_MLGAIN_H][1:0], regs_r[sig_pkg::SIG_I_MLGAIN_L]}
    : {regs_r[sig_pkg::SIG_I_LGOUT_H][2:0], regs_r[sig_pkg::SIG_I_LGOUT_L]};
  assign short_gain_src = gconv[sig_pkg::SIG_B_SHORT_MAN]
    ? {1'b0, regs_r[sig_pkg::SIG_I_MSGAIN_H][1:0], regs_r[sig_pkg::SIG_I_MSGAIN_L]}
    : {regs_r[sig_pkg::SIG_I_SGOUT_H][2:0], regs_r[sig_pkg::SIG_I_SGOUT_L]};

  assign long_gain_now  = gain_x16(long_gain_src, gconv[sig_pkg::SIG_B_LONG_REAL]);
  assign short_gain_now = gain_x16(short_gain_src, gconv[sig_pkg::SIG_B_SHORT_REAL]);

  // ************************************************************
  // Frame boundary capture
  // ************************************************************
  logic [8:0] long_gain_pend_r;
  logic [8:0] short_gain_pend_r;

  // Whole-line exposure implied by the mid byte reset values
  localparam logic [15:0] LEXP_RST =
    16'(sig_pkg::SIG_RESET[sig_pkg::SIG_I_LEXP_M]) << sig_pkg::SIG_EXP_FRAC;
  localparam logic [15:0] SEXP_RST =
    16'(sig_pkg::SIG_RESET[sig_pkg::SIG_I_SEXP_M]) << sig_pkg::SIG_EXP_FRAC;

  // Fraction bits are dropped: sub-line exposure is not supported
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      long_exposure_lines  <= LEXP_RST;
      short_exposure_lines <= SEXP_RST;
    end else if (frame_start) begin
      long_exposure_lines  <= long_exp_raw[19:sig_pkg::SIG_EXP_FRAC];
      short_exposure_lines <= short_exp_raw[19:sig_pkg::SIG_EXP_FRAC];
    end
  end

  // Pending stage holds last frame's gain for the delayed latch
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      long_gain_pend_r  <= 9'(sig_pkg::SIG_CODED_BASE);
      short_gain_pend_r <= 9'(sig_pkg::SIG_CODED_BASE);
      long_analog_gain  <= 9'(sig_pkg::SIG_CODED_BASE);
      short_analog_gain <= 9'(sig_pkg::SIG_CODED_BASE);
    end else if (frame_start) begin
      long_gain_pend_r  <= long_gain_now;
      short_gain_pend_r <= short_gain_now;
      long_analog_gain  <= gain_delay ? long_gain_pend_r : long_gain_now;
      short_analog_gain <= gain_delay ? short_gain_pend_r : short_gain_now;
    end
  end

  // Calibration may only follow gain taken from the output value registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      long_gain_blc_allowed  <= 1'b1;
      short_gain_blc_allowed <= 1'b1;
    end else if (frame_start) begin
      long_gain_blc_allowed  <= ~gconv[sig_pkg::SIG_B_LONG_MAN];
      short_gain_blc_allowed <= ~gconv[sig_pkg::SIG_B_SHORT_MAN];
    end
  end

  // ************************************************************
  // Pipeline enables and white balance
  // ************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      black_defect_removal_en    <= 1'b0;
      white_defect_removal_en    <= 1'b0;
      lens_shading_correction_en <= 1'b0;
      wb_red_gain                <= sig_pkg::SIG_WB_UNITY;
      wb_green_gain              <= sig_pkg::SIG_WB_UNITY;
      wb_blue_gain               <= sig_pkg::SIG_WB_UNITY;
    end else begin
      black_defect_removal_en    <= ctrl0[sig_pkg::SIG_B_BLACK_DEF];
      white_defect_removal_en    <= ctrl0[sig_pkg::SIG_B_WHITE_DEF];
      lens_shading_correction_en <= ctrl0[sig_pkg::SIG_B_SHADE_EN];
      wb_red_gain   <= wb_gain(regs_r[sig_pkg::SIG_I_WB_R_H], regs_r[sig_pkg::SIG_I_WB_R_H+1],
                               ctrl1[sig_pkg::SIG_B_WB_EN]);
      wb_green_gain <= wb_gain(regs_r[sig_pkg::SIG_I_WB_G_H], regs_r[sig_pkg::SIG_I_WB_G_H+1],
                               ctrl1[sig_pkg::SIG_B_WB_EN]);
      wb_blue_gain  <= wb_gain(regs_r[sig_pkg::SIG_I_WB_B_H], regs_r[sig_pkg::SIG_I_WB_B_H+1],
                               ctrl1[sig_pkg::SIG_B_WB_EN]);
    end
  end

  // ************************************************************
  // Lens shading colour points
  // ************************************************************
  logic [24:0] blue_pts;
  logic [24:0] red_pts;
  logic [3:0]  base_blue;
  logic [3:0]  base_red;

  assign base_blue = regs_r[sig_pkg::SIG_I_BASE][7:4];
  assign base_red  = regs_r[sig_pkg::SIG_I_BASE][3:0];

  for (genvar p = 0; p < sig_pkg::SIG_NPOINT; p++) begin : g_pt
    assign blue_pts[p*5 +: 5] = point_sum(regs_r[sig_pkg::SIG_I_POINT0+p][7:4], base_blue);
    assign red_pts[p*5 +: 5]  = point_sum(regs_r[sig_pkg::SIG_I_POINT0+p][3:0], base_red);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      shading_blue_points <= '0;
      shading_red_points  <= '0;
    end else begin
      shading_blue_points <= blue_pts;
      shading_red_points  <= red_pts;
    end
  end

  // ************************************************************
  // Luminance amplitude reduction at high gain
  // ************************************************************
  logic [7:0]  upper_thr;
  logic [7:0]  lower_thr;
  logic [6:0]  min_amp;
  logic [8:0]  gain_now;
  logic [8:0]  span;
  logic [8:0]  over;
  logic [6:0]  drop_range;
  logic [15:0] drop_prod;
  logic [15:0] drop;
  logic [6:0]  amp_nxt;

  assign upper_thr = regs_r[sig_pkg::SIG_I_UPPER];
  assign lower_thr = regs_r[sig_pkg::SIG_I_LOWER];
  // Out-of-range minimum is held at full amplitude
  assign min_amp   = (regs_r[sig_pkg::SIG_I_MINAMP][6:0] > sig_pkg::SIG_AMP_FULL)
                   ? sig_pkg::SIG_AMP_FULL : regs_r[sig_pkg::SIG_I_MINAMP][6:0];
  assign gain_now  = long_analog_gain;
  assign span      = {1'b0, upper_thr} - {1'b0, lower_thr};
  assign over      = gain_now - {1'b0, lower_thr};
  assign drop_range = sig_pkg::SIG_AMP_FULL - min_amp;
  assign drop_prod = 16'(drop_range) * 16'(over);
  // Divide is small; only one per frame matters, so it is left combinational
  assign drop      = (span == 9'h000) ? 16'(drop_range) : drop_prod / 16'(span);

  always_comb begin
    amp_nxt = sig_pkg::SIG_AMP_FULL;
    if (auto_shading_switch_enable) begin
      if (gain_now > {1'b0, upper_thr}) begin
        amp_nxt = min_amp;
      end else if (gain_now > {1'b0, lower_thr}) begin
        amp_nxt = sig_pkg::SIG_AMP_FULL - drop[6:0];
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      shading_lum_amplitude <= sig_pkg::SIG_AMP_FULL;
    end else begin
      shading_lum_amplitude <= amp_nxt;
    end
  end

endmodule

`default_nettype wire

// ==== sig_gain_exposure_ctrl_chk.sv ====
// Port checks for the gain and exposure control bank
`timescale 1ns/1ps
`default_nettype none

module sig_gain_exposure_ctrl_chk (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        frame_start,
  input wire logic        auto_shading_switch_enable,
  input wire logic [15:0] long_exposure_lines,
  input wire logic [15:0] short_exposure_lines,
  input wire logic [8:0]  long_analog_gain,
  input wire logic [8:0]  short_analog_gain,
  input wire logic        long_gain_blc_allowed,
  input wire logic        black_defect_removal_en,
  input wire logic        white_defect_removal_en,
  input wire logic        lens_shading_correction_en,
  input wire logic [6:0]  shading_lum_amplitude
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // ****************
  // Assertions
  // ****************
  AST_READ_ANSWER: assert property (reg_read |=> reg_rvalid)
    else $error("read strobe got no answer");
  AST_IDLE_QUIET: assert property (!reg_read |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("answer or data without a read strobe");
  AST_PIPE_ENABLES: assert property (reg_write && reg_addr == 16'h5000 |-> ##2
    {5'h00, black_defect_removal_en, white_defect_removal_en, lens_shading_correction_en}
      == ($past(reg_wdata, 2) & 8'h07))
    else $error("pipeline enables do not follow control byte");
  AST_GAIN_LIMIT: assert property (
    long_analog_gain <= 9'h100 && short_analog_gain <= 9'h100)
    else $error("analog gain above sixteen times");
  AST_AMP_LIMIT: assert property (shading_lum_amplitude <= 7'h40)
    else $error("amplitude above full scale");
  AST_AMP_FULL: assert property (
    !auto_shading_switch_enable |=> shading_lum_amplitude == 7'h40)
    else $error("amplitude reduced with switching off");
  AST_EXP_HOLD: assert property (!frame_start |=>
    $stable(long_exposure_lines) && $stable(short_exposure_lines))
    else $error("exposure changed between frames");
  AST_GAIN_HOLD: assert property (!frame_start |=> $stable(long_analog_gain)
    && $stable(short_analog_gain) && $stable(long_gain_blc_allowed))
    else $error("gain changed between frames");

  // Main scenarios reached
  COV_MANUAL: cover property (frame_start ##1 !long_gain_blc_allowed);
  COV_AMP_LOW: cover property (auto_shading_switch_enable && shading_lum_amplitude < 7'h40);
  COV_READ_RUN: cover property (reg_read ##1 reg_read);
endmodule

`default_nettype wire

// ==== test_sig_gain_exposure_ctrl.sv ====
// Self-checking bench for the gain and exposure control bank
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); \
  end \
end

module test_sig_gain_exposure_ctrl;
  logic        clock, reset, reg_write, reg_read, reg_rvalid, frame_start;
  logic        auto_shading_switch_enable, long_gain_blc_allowed, short_gain_blc_allowed;
  logic        black_defect_removal_en, white_defect_removal_en, lens_shading_correction_en;
  logic [15:0] reg_addr, long_exposure_lines, short_exposure_lines, mon_a;
  logic [7:0]  reg_wdata, reg_rdata, d, mon_e;
  logic [8:0]  long_analog_gain, short_analog_gain;
  logic [11:0] wb_red_gain, wb_green_gain, wb_blue_gain;
  logic [24:0] shading_blue_points, shading_red_points;
  logic [6:0]  shading_lum_amplitude;
  logic [2:0]  pipe_en;
  logic [7:0]  exp_q [$];
  logic [15:0] adr_q [$];
  logic [7:0]  gtab [4] = '{8'h20, 8'h30, 8'h40, 8'h50};
  logic [6:0]  atab [4] = '{7'h40, 7'h2c, 7'h18, 7'h18};
  int          miscompares = 0;
  int          checked = 0;
  int unsigned rnd;

  sig_gain_exposure_ctrl i_dut (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .reg_rvalid, .frame_start, .auto_shading_switch_enable, .long_exposure_lines,
    .short_exposure_lines, .long_analog_gain, .short_analog_gain, .long_gain_blc_allowed,
    .short_gain_blc_allowed, .wb_red_gain, .wb_green_gain, .wb_blue_gain,
    .black_defect_removal_en, .white_defect_removal_en, .lens_shading_correction_en,
    .shading_blue_points, .shading_red_points, .shading_lum_amplitude);

  assign pipe_en = {black_defect_removal_en, white_defect_removal_en, lens_shading_correction_en};

  initial clock = 1'b0;
  always #4 clock = ~clock;

  // ****************
  // Drivers and scoreboard
  // ****************
  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    reg_read = 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    adr_q.push_back(a);
    exp_q.push_back(e);
    reg_addr = a;
    reg_read = 1'b1;
    reg_write = 1'b0;
    @(negedge clock);
  endtask

  task automatic idle(input int n);
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (n) @(negedge clock);
  endtask

  // Bounded so a lost answer cannot hang the run
  task automatic drain();
    int n;
    n = 0;
    idle(1);
    while (exp_q.size() != 0 && n < 16) begin
      n++;
      @(negedge clock);
    end
    if (exp_q.size() != 0) begin
      miscompares++;
      results();
    end
  endtask

  task automatic frm(input logic [8:0] lg, input logic [8:0] sg, input logic [1:0] bl);
    idle(1);
    frame_start = 1'b1;
    @(negedge clock);
    frame_start = 1'b0;
    @(negedge clock);
    `CHK("long gain", lg, long_analog_gain)
    `CHK("short gain", sg, short_analog_gain)
    `CHK("calibration allowed", bl, {long_gain_blc_allowed, short_gain_blc_allowed})
  endtask

  always @(negedge clock) begin
    if (!reset && reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK("pending read", 1'b1, 1'b0)
      end else begin
        mon_a = adr_q.pop_front();
        mon_e = exp_q.pop_front();
        `CHK($sformatf("register %0h", mon_a), mon_e, reg_rdata)
      end
    end
  end

  // ****************
  // Tests
  // ****************
  initial begin
    rnd = $urandom(32'h5a96710d);
    {reset, reg_write, reg_read, frame_start, auto_shading_switch_enable} = 5'b10000;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    repeat (5) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    for (int i = 0; i < sig_pkg::SIG_NREG; i++) begin
      rd(sig_pkg::SIG_ADDR[i], sig_pkg::SIG_RESET[i]);
    end
    rd(16'h350c, 8'h00);
    drain();
    `CHK("long exposure", 16'h0020, long_exposure_lines)
    `CHK("long gain", 9'h010, long_analog_gain)
    `CHK("blue points", {5{5'h12}}, shading_blue_points)
    `CHK("red points", {5{5'h12}}, shading_red_points)
    $display("test reset values done");
    for (int i = 0; i < sig_pkg::SIG_NREG; i++) begin
      d = 8'($urandom());
      if (i == sig_pkg::SIG_I_MINAMP) d = d % 8'd65;
      if (i == sig_pkg::SIG_I_LEXP_L || i == sig_pkg::SIG_I_SEXP_L) d = d & 8'hf0;
      if (i == sig_pkg::SIG_I_MANUAL) d = d | 8'h07;
      wr(sig_pkg::SIG_ADDR[i], d);
      rd(sig_pkg::SIG_ADDR[i], d & sig_pkg::SIG_MASK[i]);
    end
    wr(16'h3510, 8'hff);
    rd(16'h3510, 8'h00);
    drain();
    reset = 1'b1;
    idle(2);
    reset = 1'b0;
    rd(16'h5240, 8'h18);
    drain();
    $display("test register access done");
    wr(16'h5000, 8'h05);
    wr(16'h5001, 8'h03);
    wr(16'h5056, 8'h0a);
    wr(16'h5057, 8'hbc);
    wr(16'h505a, 8'hf5);
    wr(16'h505b, 8'h67);
    wr(16'h5238, 8'h3c);
    wr(16'h523d, 8'h21);
    idle(3);
    `CHK("defect enables", 3'b101, pipe_en)
    `CHK("red balance", 12'habc, wb_red_gain)
    `CHK("blue balance", 12'h567, wb_blue_gain)
    `CHK("green balance", 12'h400, wb_green_gain)
    `CHK("blue points", {{4{5'h0c}}, 5'h05}, shading_blue_points)
    `CHK("red points", {{4{5'h0b}}, 5'h0d}, shading_red_points)
    wr(16'h5001, 8'h01);
    wr(16'h5000, 8'h02);
    idle(3);
    `CHK("red balance", 12'h400, wb_red_gain)
    `CHK("blue balance", 12'h400, wb_blue_gain)
    `CHK("defect enables", 3'b010, pipe_en)
    $display("test pipeline controls done");
    wr(16'h3500, 8'h01);
    wr(16'h3501, 8'h23);
    wr(16'h3502, 8'h40);
    wr(16'h3506, 8'h0f);
    wr(16'h3507, 8'hff);
    wr(16'h3508, 8'hf0);
    wr(16'h3503, 8'h07);
    wr(16'h3509, 8'h00);
    wr(16'h350b, 8'h35);
    wr(16'h350e, 8'h03);
    wr(16'h350f, 8'hff);
    idle(2);
    `CHK("long exposure", 16'h0020, long_exposure_lines)
    frm(9'h054, 9'h100, 2'b11);
    `CHK("long exposure", 16'h1234, long_exposure_lines)
    `CHK("short exposure", 16'hffff, short_exposure_lines)
    wr(16'h3509, 8'h12);
    wr(16'h350b, 8'h28);
    wr(16'h350e, 8'h07);
    frm(9'h028, 9'h100, 2'b11);
    wr(16'h3509, 8'h19);
    wr(16'h3504, 8'h01);
    wr(16'h3515, 8'h13);
    frm(9'h100, 9'h026, 2'b00);
    wr(16'h3509, 8'h10);
    wr(16'h350b, 8'h20);
    frm(9'h020, 9'h100, 2'b11);
    wr(16'h3503, 8'h37);
    wr(16'h350b, 8'h40);
    frm(9'h020, 9'h100, 2'b11);
    frm(9'h040, 9'h100, 2'b11);
    wr(16'h3503, 8'h17);
    wr(16'h350b, 8'h50);
    frm(9'h050, 9'h100, 2'b11);
    wr(16'h3503, 8'h27);
    wr(16'h350b, 8'h60);
    frm(9'h060, 9'h100, 2'b11);
    $display("test frame capture done");
    wr(16'h3503, 8'h07);
    auto_shading_switch_enable = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(16'h350b, gtab[k]);
      frm({1'b0, gtab[k]}, 9'h100, 2'b11);
      idle(2);
      `CHK("amplitude", atab[k], shading_lum_amplitude)
    end
    wr(16'h5240, 8'h00);
    idle(3);
    `CHK("amplitude", 7'h00, shading_lum_amplitude)
    auto_shading_switch_enable = 1'b0;
    idle(3);
    `CHK("amplitude", 7'h40, shading_lum_amplitude)
    $display("test amplitude done");
    drain();
    results();
  end
endmodule

bind sig_gain_exposure_ctrl sig_gain_exposure_ctrl_chk i_chk (.clock, .reset, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid, .frame_start,
  .auto_shading_switch_enable, .long_exposure_lines, .short_exposure_lines, .long_analog_gain,
  .short_analog_gain, .long_gain_blc_allowed, .black_defect_removal_en,
  .white_defect_removal_en, .lens_shading_correction_en, .shading_lum_amplitude);

`default_nettype wire
